// [core/rcd_pkg.sv]
// rcd_pkg: register map, field positions, reset values and timing of the ranging command decoder
package rcd_pkg;
	// ==========================================================
	// register offsets
	localparam logic [7:0] CMD_OFS = 8'h10;
	localparam logic [7:0] PARAM9_OFS = 8'h06;
	localparam logic [7:0] PARAM0_OFS = 8'h0F;
	localparam logic [7:0] TAG_OFS = 8'h1E;
	localparam logic [7:0] INT_STATUS_OFS = 8'hE1;
	localparam logic [7:0] INT_ENAB_OFS = 8'hE2;
	localparam int PARAM_NUM = 10;
	// ==========================================================
	// command codes and reset values
	localparam logic [7:0] CMD_NONE = 8'h00;
	localparam logic [7:0] CMD_MEAS_CAL = 8'h02;
	localparam logic [7:0] CMD_MEAS = 8'h03;
	localparam logic [7:0] BYTE_RST = 8'h00;
	localparam logic BIT_RST = 1'b0;
	// ==========================================================
	// parameter byte indices and field positions
	localparam int MASK_IDX = 7;
	localparam int ALG_IDX = 6;
	localparam int SPREAD_IDX = 3;
	localparam int PERIOD_IDX = 2;
	localparam int ITER_LO_IDX = 1;
	localparam int ITER_HI_IDX = 0;
	localparam int FACTORY_BIT = 0;
	localparam int ALGSTATE_BIT = 1;
	localparam int HALF_BIT = 2;
	localparam int EARLY_BIT = 4;
	localparam int COMBINED_BIT = 5;
	localparam int SPREAD_BIT = 6;
	localparam int NOSTBY_BIT = 7;
	// ==========================================================
	// serial bus address (value arbitrary) and bit count per byte
	localparam logic [6:0] I2C_ADDR_DFLT = 7'h2A;
	localparam logic [3:0] BYTE_BITS = 4'h8;
	// ==========================================================
	// timing: one millisecond of the repetition period
	localparam int MS_NS = 1000000;
	localparam int CLK_NS = 5;
	localparam int CYC_PER_MS = MS_NS / CLK_NS;
	// ==========================================================
	// state types
	typedef enum logic [2:0] {
		S_IDLE = 3'b000, S_ADDR = 3'b001, S_AACK = 3'b010, S_WDAT = 3'b011,
		S_WACK = 3'b100, S_RDAT = 3'b101, S_RACK = 3'b110
	} rcd_bus_st_t;
	typedef enum logic [1:0] {
		M_IDLE = 2'b00, M_RUN = 2'b01, M_WAIT = 2'b10
	} rcd_meas_st_t;
endpackage

// [core/rcd_i2c_slave.sv]
// rcd_i2c_slave: serial register port slave, byte writes and auto-increment reads
`timescale 1ns/10ps
module rcd_i2c_slave #(
	parameter logic [6:0] DEV_ADDR = rcd_pkg::I2C_ADDR_DFLT
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic scl,
	input wire logic sda_in,
	output logic sda_oe,
	output logic wr_stb,
	output logic [7:0] wr_addr,
	output logic [7:0] wr_data,
	output logic [7:0] rd_addr,
	input wire logic [7:0] rd_data
);
	// ==========================================================
	// pin synchronisers and edge detection
	logic scl_s1_reg, scl_s2_reg, scl_d_reg, sda_s1_reg, sda_s2_reg, sda_d_reg;
	logic scl_rise, scl_fall, start_c, stop_c;
	assign scl_rise = scl_s2_reg & ~scl_d_reg;
	assign scl_fall = ~scl_s2_reg & scl_d_reg;
	assign start_c = scl_s2_reg & scl_d_reg & sda_d_reg & ~sda_s2_reg;
	assign stop_c = scl_s2_reg & scl_d_reg & ~sda_d_reg & sda_s2_reg;
	// ==========================================================
	// byte engine
	rcd_pkg::rcd_bus_st_t st_reg, st_next;
	logic [3:0] cnt_reg, cnt_next;
	logic [7:0] sh_reg, sh_next, tx_reg, tx_next, ptr_reg, ptr_next, wa_reg, wa_next, wd_reg, wd_next;
	logic rw_reg, rw_next, first_reg, first_next, nack_reg, nack_next, oe_reg, oe_next, stb_reg, stb_next;
	// next state; the slave only changes sda after a falling scl so data stays put while scl is high
	always_comb begin
		st_next = st_reg;
		cnt_next = cnt_reg;
		sh_next = sh_reg;
		tx_next = tx_reg;
		ptr_next = ptr_reg;
		wa_next = wa_reg;
		wd_next = wd_reg;
		rw_next = rw_reg;
		first_next = first_reg;
		nack_next = nack_reg;
		oe_next = oe_reg;
		stb_next = 1'b0;
		if (start_c) begin
			st_next = rcd_pkg::S_ADDR;
			cnt_next = 4'h0;
			oe_next = 1'b0;
		end else if (stop_c) begin
			st_next = rcd_pkg::S_IDLE;
			oe_next = 1'b0;
		end else if (scl_rise) begin
			if (st_reg == rcd_pkg::S_RACK) begin
				nack_next = sda_s2_reg;
			end else if (st_reg == rcd_pkg::S_ADDR || st_reg == rcd_pkg::S_WDAT || st_reg == rcd_pkg::S_RDAT) begin
				sh_next = {sh_reg[6:0], sda_s2_reg};
				cnt_next = cnt_reg + 4'h1;
			end
		end else if (scl_fall) begin
			case (st_reg)
				rcd_pkg::S_ADDR: begin
					if (cnt_reg == rcd_pkg::BYTE_BITS) begin
						if (sh_reg[7:1] == DEV_ADDR) begin
							st_next = rcd_pkg::S_AACK;
							oe_next = 1'b1;
							rw_next = sh_reg[0];
						end else begin
							st_next = rcd_pkg::S_IDLE;
						end
					end
				end
				rcd_pkg::S_AACK, rcd_pkg::S_RACK: begin
					cnt_next = 4'h0;
					if (st_reg == rcd_pkg::S_RACK && nack_reg) begin
						st_next = rcd_pkg::S_IDLE;
						oe_next = 1'b0;
					end else if (st_reg == rcd_pkg::S_RACK || rw_reg) begin
						st_next = rcd_pkg::S_RDAT;
						tx_next = rd_data;
						ptr_next = ptr_reg + 8'h01;
						oe_next = ~rd_data[7];
					end else begin
						st_next = rcd_pkg::S_WDAT;
						oe_next = 1'b0;
						first_next = 1'b1;
					end
				end
				rcd_pkg::S_WDAT: begin
					if (cnt_reg == rcd_pkg::BYTE_BITS) begin
						st_next = rcd_pkg::S_WACK;
						oe_next = 1'b1;
						if (first_reg) begin
							ptr_next = sh_reg;
						end else begin
							stb_next = 1'b1;
							wa_next = ptr_reg;
							wd_next = sh_reg;
						end
					end
				end
				rcd_pkg::S_WACK: begin
					st_next = rcd_pkg::S_WDAT;
					oe_next = 1'b0;
					cnt_next = 4'h0;
					first_next = 1'b0;
					if (!first_reg) begin
						ptr_next = ptr_reg + 8'h01;
					end
				end
				rcd_pkg::S_RDAT: begin
					if (cnt_reg == rcd_pkg::BYTE_BITS) begin
						st_next = rcd_pkg::S_RACK;
						oe_next = 1'b0;
					end else begin
						tx_next = {tx_reg[6:0], 1'b0};
						oe_next = ~tx_reg[6];
					end
				end
				default: begin
					st_next = rcd_pkg::S_IDLE;
				end
			endcase
		end
	end
	// registers, synchronous reset
	always_ff @(posedge clk) begin
		scl_s1_reg <= scl;
		scl_s2_reg <= scl_s1_reg;
		sda_s1_reg <= sda_in;
		sda_s2_reg <= sda_s1_reg;
		if (!rst_n) begin
			scl_d_reg <= 1'b1;
			sda_d_reg <= 1'b1;
			st_reg <= rcd_pkg::S_IDLE;
			cnt_reg <= 4'h0;
			sh_reg <= rcd_pkg::BYTE_RST;
			tx_reg <= rcd_pkg::BYTE_RST;
			ptr_reg <= rcd_pkg::BYTE_RST;
			wa_reg <= rcd_pkg::BYTE_RST;
			wd_reg <= rcd_pkg::BYTE_RST;
			rw_reg <= 1'b0;
			first_reg <= 1'b0;
			nack_reg <= 1'b0;
			oe_reg <= 1'b0;
			stb_reg <= 1'b0;
		end else begin
			scl_d_reg <= scl_s2_reg;
			sda_d_reg <= sda_s2_reg;
			st_reg <= st_next;
			cnt_reg <= cnt_next;
			sh_reg <= sh_next;
			tx_reg <= tx_next;
			ptr_reg <= ptr_next;
			wa_reg <= wa_next;
			wd_reg <= wd_next;
			rw_reg <= rw_next;
			first_reg <= first_next;
			nack_reg <= nack_next;
			oe_reg <= oe_next;
			stb_reg <= stb_next;
		end
	end
	assign sda_oe = oe_reg;
	assign wr_stb = stb_reg;
	assign wr_addr = wa_reg;
	assign wr_data = wd_reg;
	assign rd_addr = ptr_reg;
endmodule

// [core/rcd_top.sv]
// rcd_top: ranging command decoder, command and parameter registers driving measurement control
`timescale 1ns/10ps
module rcd_top #(
	parameter int MS_CYCLES = rcd_pkg::CYC_PER_MS
) (
	input wire logic CORE_CLK,
	input wire logic RST_N,
	input wire logic SCL,
	input wire logic SDA_IN,
	output logic SDA_OUT,
	output logic SDA_OE,
	input wire logic MEAS_DONE,
	input wire logic GPIO_ABORT,
	output logic MEAS_START,
	output logic EMITTER_CLOCK_HALF,
	output logic ACTIVE_TIME_DOUBLE,
	output logic EARLY_ABORT_REPORT,
	output logic COMBINED_HIST,
	output logic NO_STANDBY,
	output logic SPREAD_SPECTRUM,
	output logic FACTORY_CAL_PRESENT,
	output logic ALG_STATE_PRESENT,
	output logic [15:0] ITERATIONS,
	output logic INT_N
);
	// ==========================================================
	// register port
	logic wr_stb, sda_oe_w;
	logic [7:0] wr_addr, wr_data, rd_addr;
	logic [7:0] cmd_reg, cmd_next, tag_reg, tag_next, alg_reg, alg_next, period_reg, period_next;
	logic [7:0] elapsed_reg, elapsed_next, spread_reg, spread_next;
	logic [1:0] mask_reg, mask_next;
	logic [15:0] iter_reg, iter_next;
	logic [31:0] ms_cnt_reg, ms_cnt_next;
	logic enab_reg, enab_next, flag_reg, flag_next, start_reg, start_next, int_n_reg, int_n_next;
	logic [7:0] prm_reg [rcd_pkg::PARAM_NUM];
	logic [7:0] prm_next [rcd_pkg::PARAM_NUM];
	rcd_pkg::rcd_meas_st_t st_reg, st_next;
	logic wr_cmd, start_req, stop_req, done_evt, period_met;

	rcd_i2c_slave i_rcd_i2c_slave (
		.clk(CORE_CLK),
		.rst_n(RST_N),
		.scl(SCL),
		.sda_in(SDA_IN),
		.sda_oe(sda_oe_w),
		.wr_stb(wr_stb),
		.wr_addr(wr_addr),
		.wr_data(wr_data),
		.rd_addr(rd_addr),
		.rd_data(read_reg(rd_addr))
	);

	// read decode; parameter bytes are write only and read back zero
	function automatic logic [7:0] read_reg(input logic [7:0] a);
		logic [7:0] v;
		v = rcd_pkg::BYTE_RST;
		case (a)
			rcd_pkg::CMD_OFS: v = cmd_reg;
			rcd_pkg::TAG_OFS: v = tag_reg;
			rcd_pkg::INT_STATUS_OFS: v = {7'h00, flag_reg};
			rcd_pkg::INT_ENAB_OFS: v = {7'h00, enab_reg};
			default: v = rcd_pkg::BYTE_RST;
		endcase
		return v;
	endfunction

	// ==========================================================
	// command decode
	assign wr_cmd = wr_stb && (wr_addr == rcd_pkg::CMD_OFS);
	assign start_req = wr_cmd && (wr_data == rcd_pkg::CMD_MEAS_CAL || wr_data == rcd_pkg::CMD_MEAS);
	assign stop_req = wr_cmd && (wr_data == rcd_pkg::CMD_NONE);
	assign period_met = (elapsed_reg >= period_reg);

	// next values of registers, sequencer, timer and result flag
	always_comb begin
		cmd_next = cmd_reg;
		enab_next = enab_reg;
		tag_next = tag_reg;
		alg_next = alg_reg;
		mask_next = mask_reg;
		period_next = period_reg;
		spread_next = spread_reg;
		iter_next = iter_reg;
		st_next = st_reg;
		start_next = 1'b0;
		done_evt = 1'b0;
		ms_cnt_next = ms_cnt_reg;
		elapsed_next = elapsed_reg;
		for (int i = 0; i < rcd_pkg::PARAM_NUM; i++) begin
			prm_next[i] = prm_reg[i];
			if (wr_stb && wr_addr == rcd_pkg::PARAM0_OFS - 8'(i)) begin
				prm_next[i] = wr_data;
			end
		end
		// elapsed milliseconds since the last start, saturating
		if (ms_cnt_reg == 32'(MS_CYCLES - 1)) begin
			ms_cnt_next = 32'h0;
			if (elapsed_reg != 8'hFF) begin
				elapsed_next = elapsed_reg + 8'h01;
			end
		end else begin
			ms_cnt_next = ms_cnt_reg + 32'h1;
		end
		case (st_reg)
			rcd_pkg::M_RUN: begin
				if (GPIO_ABORT && alg_reg[rcd_pkg::EARLY_BIT]) begin
					done_evt = 1'b1;
				end else if (MEAS_DONE) begin
					done_evt = 1'b1;
					if (period_reg == rcd_pkg::BYTE_RST) begin
						st_next = rcd_pkg::M_IDLE;
						cmd_next = rcd_pkg::CMD_NONE;
					end else if (period_met) begin
						start_next = 1'b1;
						ms_cnt_next = 32'h0;
						elapsed_next = rcd_pkg::BYTE_RST;
					end else begin
						st_next = rcd_pkg::M_WAIT;
					end
				end
			end
			rcd_pkg::M_WAIT: begin
				if (period_met) begin
					st_next = rcd_pkg::M_RUN;
					start_next = 1'b1;
					ms_cnt_next = 32'h0;
					elapsed_next = rcd_pkg::BYTE_RST;
				end
			end
			rcd_pkg::M_IDLE: begin
				st_next = rcd_pkg::M_IDLE;
			end
			default: begin
				st_next = rcd_pkg::M_IDLE;
			end
		endcase
		if (done_evt) begin
			tag_next = tag_reg + 8'h01;
		end
		// a host write to the command register beats the automatic clear
		if (wr_cmd) begin
			cmd_next = wr_data;
		end
		if (stop_req) begin
			st_next = rcd_pkg::M_IDLE;
			start_next = 1'b0;
		end
		// parameters are taken when the code lands, so they must already be written
		if (start_req) begin
			st_next = rcd_pkg::M_RUN;
			start_next = 1'b1;
			ms_cnt_next = 32'h0;
			elapsed_next = rcd_pkg::BYTE_RST;
			alg_next = prm_reg[rcd_pkg::ALG_IDX];
			spread_next = prm_reg[rcd_pkg::SPREAD_IDX];
			period_next = prm_reg[rcd_pkg::PERIOD_IDX];
			iter_next = {prm_reg[rcd_pkg::ITER_HI_IDX], prm_reg[rcd_pkg::ITER_LO_IDX]};
			mask_next = 2'h0;
			if (wr_data == rcd_pkg::CMD_MEAS_CAL) begin
				mask_next = prm_reg[rcd_pkg::MASK_IDX][1:0];
			end
		end
		if (wr_stb && wr_addr == rcd_pkg::INT_ENAB_OFS) begin
			enab_next = wr_data[0];
		end
		// write one clears; a result in the same cycle wins
		flag_next = flag_reg;
		if (wr_stb && wr_addr == rcd_pkg::INT_STATUS_OFS && wr_data[0]) begin
			flag_next = 1'b0;
		end
		if (done_evt) begin
			flag_next = 1'b1;
		end
		int_n_next = ~(flag_next & enab_next);
	end

	// registers, synchronous reset
	always_ff @(posedge CORE_CLK) begin
		if (!RST_N) begin
			cmd_reg <= rcd_pkg::BYTE_RST;
			enab_reg <= rcd_pkg::BIT_RST;
			flag_reg <= rcd_pkg::BIT_RST;
			tag_reg <= rcd_pkg::BYTE_RST;
			alg_reg <= rcd_pkg::BYTE_RST;
			mask_reg <= 2'h0;
			period_reg <= rcd_pkg::BYTE_RST;
			spread_reg <= rcd_pkg::BYTE_RST;
			iter_reg <= 16'h0000;
			st_reg <= rcd_pkg::M_IDLE;
			start_reg <= 1'b0;
			int_n_reg <= 1'b1;
			ms_cnt_reg <= 32'h0;
			elapsed_reg <= rcd_pkg::BYTE_RST;
			for (int i = 0; i < rcd_pkg::PARAM_NUM; i++) begin
				prm_reg[i] <= rcd_pkg::BYTE_RST;
			end
		end else begin
			cmd_reg <= cmd_next;
			enab_reg <= enab_next;
			flag_reg <= flag_next;
			tag_reg <= tag_next;
			alg_reg <= alg_next;
			mask_reg <= mask_next;
			period_reg <= period_next;
			spread_reg <= spread_next;
			iter_reg <= iter_next;
			st_reg <= st_next;
			start_reg <= start_next;
			int_n_reg <= int_n_next;
			ms_cnt_reg <= ms_cnt_next;
			elapsed_reg <= elapsed_next;
			for (int i = 0; i < rcd_pkg::PARAM_NUM; i++) begin
				prm_reg[i] <= prm_next[i];
			end
		end
	end

	// ==========================================================
	// outputs, all straight from flops except SDA_OUT, which is tied low
	assign SDA_OUT = 1'b0; // open drain: only the enable moves
	assign SDA_OE = sda_oe_w;
	assign MEAS_START = start_reg;
	assign EMITTER_CLOCK_HALF = alg_reg[rcd_pkg::HALF_BIT];
	assign ACTIVE_TIME_DOUBLE = alg_reg[rcd_pkg::HALF_BIT];
	assign EARLY_ABORT_REPORT = alg_reg[rcd_pkg::EARLY_BIT];
	assign COMBINED_HIST = alg_reg[rcd_pkg::COMBINED_BIT];
	assign NO_STANDBY = alg_reg[rcd_pkg::NOSTBY_BIT];
	assign SPREAD_SPECTRUM = spread_reg[rcd_pkg::SPREAD_BIT];
	assign FACTORY_CAL_PRESENT = mask_reg[rcd_pkg::FACTORY_BIT];
	assign ALG_STATE_PRESENT = mask_reg[rcd_pkg::ALGSTATE_BIT];
	assign ITERATIONS = iter_reg;
	assign INT_N = int_n_reg;

	// ==========================================================
	// assertions
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (!RST_N);

	cmd_write_a: assert property (wr_cmd |=> cmd_reg == $past(wr_data))
		else $error("command register lost a write");
	cal_start_a: assert property (wr_cmd && wr_data == rcd_pkg::CMD_MEAS_CAL |=> MEAS_START &&
		mask_reg == $past(prm_reg[rcd_pkg::MASK_IDX][1:0]))
		else $error("code 0x02 did not start with its mask");
	plain_start_a: assert property (wr_cmd && wr_data == rcd_pkg::CMD_MEAS |=>
		MEAS_START && !FACTORY_CAL_PRESENT && !ALG_STATE_PRESENT)
		else $error("code 0x03 start wrong");
	alg_latch_a: assert property (start_req |=> alg_reg == $past(prm_reg[rcd_pkg::ALG_IDX]))
		else $error("algorithm byte not taken at start");
	// halving and doubling must both follow the algorithm byte taken at start, not just each other
	half_double_a: assert property (start_req |=> ACTIVE_TIME_DOUBLE == EMITTER_CLOCK_HALF &&
		EMITTER_CLOCK_HALF == $past(prm_reg[rcd_pkg::ALG_IDX][rcd_pkg::HALF_BIT]))
		else $error("halved clock without doubled interval");
	early_report_a: assert property (st_reg == rcd_pkg::M_RUN && GPIO_ABORT && EARLY_ABORT_REPORT &&
		!wr_stb |=> flag_reg && tag_reg == $past(tag_reg) + 8'h01 && (!INT_N || !enab_reg))
		else $error("early abort not reported");
	late_report_a: assert property (st_reg == rcd_pkg::M_RUN && GPIO_ABORT && !EARLY_ABORT_REPORT &&
		!MEAS_DONE |=> $stable(tag_reg))
		else $error("abort reported while early report off");
	result_int_a: assert property (done_evt && enab_next |=> !INT_N && flag_reg)
		else $error("result interrupt not driven");
	single_shot_a: assert property (st_reg == rcd_pkg::M_RUN && MEAS_DONE && !GPIO_ABORT &&
		period_reg == rcd_pkg::BYTE_RST && !wr_cmd |=> st_reg == rcd_pkg::M_IDLE && cmd_reg == rcd_pkg::CMD_NONE)
		else $error("single measurement did not stop");

	cal_start_c: cover property (wr_cmd && wr_data == rcd_pkg::CMD_MEAS_CAL ##1 MEAS_START);
	early_abort_c: cover property (st_reg == rcd_pkg::M_RUN && GPIO_ABORT && EARLY_ABORT_REPORT);
	repeat_run_c: cover property (st_reg == rcd_pkg::M_WAIT ##[1:1000] MEAS_START);
	int_drive_c: cover property ($fell(INT_N));
endmodule

// [verification/rcd_host.sv]
// rcd_host: behavioural host master driving the serial register port
`timescale 1ns/10ps
module rcd_host (
	output logic scl,
	output logic sda,
	input wire logic sda_line
);
	int nacks;
	// ==========================================================
	// idle bus: both lines released, clock stands still between frames
	initial begin
		scl = 1'b1;
		sda = 1'b1;
		nacks = 0;
	end
	// start, or repeated start from a low clock
	task automatic start();
		sda = 1'b1;
		#40 scl = 1'b1;
		#40 sda = 1'b0;
		#40 scl = 1'b0;
	endtask
	task automatic stop();
		#40 sda = 1'b0;
		#40 scl = 1'b1;
		#40 sda = 1'b1;
		#40;
	endtask
	// one 160 ns bit: data moves only while the clock is low
	task automatic clk_bit(input logic b, output logic s);
		#40 sda = b;
		#40 scl = 1'b1;
		#40 s = sda_line;
		#40 scl = 1'b0;
	endtask
	// byte out msb first, then the slave acknowledge slot
	task automatic send(input logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			clk_bit(d[i], s);
		end
		clk_bit(1'b1, s);
		if (s !== 1'b0) begin
			nacks++;
		end
	endtask
	// burst write; parameters go out ahead of the command byte
	task automatic wr(input logic [7:0] ptr, input logic [7:0] q[$]);
		start();
		send({rcd_pkg::I2C_ADDR_DFLT, 1'b0});
		send(ptr);
		foreach (q[i]) begin
			send(q[i]);
		end
		stop();
	endtask
	// single byte read ended by a nack
	task automatic rd(input logic [7:0] ptr, output logic [7:0] d);
		logic s;
		start();
		send({rcd_pkg::I2C_ADDR_DFLT, 1'b0});
		send(ptr);
		start();
		send({rcd_pkg::I2C_ADDR_DFLT, 1'b1});
		for (int i = 7; i >= 0; i--) begin
			clk_bit(1'b1, s);
			d[i] = s;
		end
		clk_bit(1'b1, s);
		stop();
	endtask
endmodule

// [verification/rcd_top_tb.sv]
// rcd_top_tb: self-checking bench for the ranging command decoder
`timescale 1ns/10ps
module rcd_top_tb;
	localparam int MS = 20;
	logic clk, rst_n, meas_done, gpio_abort, scl, host_sda, sda_out, sda_oe, meas_start;
	logic half, dbl, early, comb, nostby, spread, fcal, astate, int_n;
	logic [15:0] iters;
	wire logic sda_w;
	int failures, tests_run, starts;
	// ==========================================================
	// clock, open-drain data wire, pulse counter
	always #2.5 clk = ~clk;
	assign sda_w = host_sda & ~(sda_oe & ~sda_out);
	always @(posedge clk) begin
		if (meas_start === 1'b1) begin
			starts <= starts + 1;
		end
	end
	rcd_host i_rcd_host (.scl(scl), .sda(host_sda), .sda_line(sda_w));
	rcd_top #(.MS_CYCLES(MS)) i_rcd_top (.CORE_CLK(clk), .RST_N(rst_n), .SCL(scl), .SDA_IN(sda_w),
		.SDA_OUT(sda_out), .SDA_OE(sda_oe), .MEAS_DONE(meas_done), .GPIO_ABORT(gpio_abort),
		.MEAS_START(meas_start), .EMITTER_CLOCK_HALF(half), .ACTIVE_TIME_DOUBLE(dbl),
		.EARLY_ABORT_REPORT(early), .COMBINED_HIST(comb), .NO_STANDBY(nostby), .SPREAD_SPECTRUM(spread),
		.FACTORY_CAL_PRESENT(fcal), .ALG_STATE_PRESENT(astate), .ITERATIONS(iters), .INT_N(int_n));
	// ==========================================================
	// shared helpers
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected at %0t: got %h, want %h", $time, seen, exp);
		end
	endtask
	task automatic test_done();
		$display("failures %0d, tests_run %0d", failures, tests_run);
		if (failures == 0 && tests_run > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic wreg(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] q[$];
		q = {d};
		i_rcd_host.wr(a, q);
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] d;
		i_rcd_host.rd(a, d);
		chk({8'h00, d}, {8'h00, exp});
	endtask
	// one burst from 0x06 up to the command byte
	task automatic meas(input logic [7:0] code, mask, alg, spr, per);
		logic [7:0] q[$];
		q = {8'h00, 8'h00, mask, alg, 8'h00, 8'h00, spr, per, 8'h34, 8'h12, code};
		i_rcd_host.wr(rcd_pkg::PARAM9_OFS, q);
	endtask
	// one-cycle engine pulse, then let the flag land
	task automatic pulse(input logic abort);
		@(negedge clk);
		gpio_abort = abort;
		meas_done = ~abort;
		@(negedge clk);
		gpio_abort = 1'b0;
		meas_done = 1'b0;
		@(negedge clk);
	endtask
	// ==========================================================
	// scenarios
	task automatic t_reset();
		rdchk(rcd_pkg::CMD_OFS, rcd_pkg::CMD_NONE);
		rdchk(8'h40, 8'h00);
		rdchk(rcd_pkg::TAG_OFS, 8'h00);
		chk({half, dbl, early, comb, nostby, spread, fcal, astate, int_n}, 16'h0001);
		chk(16'(starts), 16'h0000);
	endtask
	// every option bit on; mask byte must be ignored for this code
	task automatic t_plain();
		meas(rcd_pkg::CMD_MEAS, 8'h03, 8'hB7, 8'h40, 8'h00);
		chk(16'(starts), 16'h0001);
		chk({half, dbl}, 16'h0003);
		chk({early, comb, nostby}, 16'h0007);
		chk({spread, fcal, astate}, 16'h0004);
		chk(iters, 16'h1234);
		rdchk(rcd_pkg::CMD_OFS, rcd_pkg::CMD_MEAS);
	endtask
	task automatic t_cal();
		meas(rcd_pkg::CMD_MEAS_CAL, 8'h01, 8'h03, 8'h00, 8'h00);
		chk({fcal, astate}, 16'h0002);
		chk({half, dbl, early, comb, nostby, spread}, 16'h0000);
		chk(iters, 16'h1234);
		meas(rcd_pkg::CMD_MEAS_CAL, 8'h03, 8'h03, 8'h00, 8'h00);
		chk({fcal, astate}, 16'h0003);
		chk(16'(starts), 16'h0003);
		wreg(rcd_pkg::INT_ENAB_OFS, 8'h01);
		pulse(1'b0);
		chk({15'h0000, int_n}, 16'h0000);
		rdchk(rcd_pkg::CMD_OFS, rcd_pkg::CMD_NONE);
		rdchk(rcd_pkg::TAG_OFS, 8'h01);
		chk(16'(starts), 16'h0003);
		wreg(rcd_pkg::INT_STATUS_OFS, 8'h01);
		chk({15'h0000, int_n}, 16'h0001);
	endtask
	task automatic t_abort();
		meas(rcd_pkg::CMD_MEAS, 8'h00, 8'h13, 8'h00, 8'h00);
		pulse(1'b1);
		chk({15'h0000, int_n}, 16'h0000);
		wreg(rcd_pkg::INT_STATUS_OFS, 8'h01);
		meas(rcd_pkg::CMD_MEAS, 8'h00, 8'h03, 8'h00, 8'h00);
		pulse(1'b1);
		chk({15'h0000, int_n}, 16'h0001);
		rdchk(rcd_pkg::TAG_OFS, 8'h02);
		pulse(1'b0);
		chk({15'h0000, int_n}, 16'h0000);
		wreg(rcd_pkg::INT_STATUS_OFS, 8'h01);
	endtask
	// 1 ms period: repeats once per completion, write of zero stops it
	task automatic t_repeat();
		int s0;
		meas(rcd_pkg::CMD_MEAS, 8'h00, 8'h03, 8'h00, 8'h01);
		s0 = starts;
		pulse(1'b0);
		repeat (3 * MS) @(negedge clk);
		chk(16'(starts), 16'(s0 + 1));
		wreg(rcd_pkg::CMD_OFS, rcd_pkg::CMD_NONE);
		s0 = starts;
		pulse(1'b0);
		repeat (3 * MS) @(negedge clk);
		chk(16'(starts), 16'(s0));
	endtask
	// 8 ms period: an early completion waits out the period, then starts once; other codes are only stored
	task automatic t_wait();
		int s0;
		meas(rcd_pkg::CMD_MEAS, 8'h00, 8'h03, 8'h00, 8'h08);
		s0 = starts;
		pulse(1'b0);
		repeat (3 * MS) @(negedge clk);
		chk(16'(starts), 16'(s0));
		repeat (3 * MS) @(negedge clk);
		chk(16'(starts), 16'(s0 + 1));
		wreg(rcd_pkg::CMD_OFS, 8'h05);
		rdchk(rcd_pkg::CMD_OFS, 8'h05);
		chk(16'(starts), 16'(s0 + 1));
		wreg(rcd_pkg::CMD_OFS, rcd_pkg::CMD_NONE);
		wreg(rcd_pkg::INT_STATUS_OFS, 8'h01);
		chk({15'h0000, int_n}, 16'h0001);
	endtask
	// ==========================================================
	// main sequence and watchdog
	initial begin
		clk = 1'b0;
		rst_n = 1'b0;
		meas_done = 1'b0;
		gpio_abort = 1'b0;
		failures = 0;
		tests_run = 0;
		starts = 0;
		repeat (4) @(negedge clk);
		rst_n = 1'b1;
		repeat (3) @(negedge clk);
		t_reset();
		t_plain();
		t_cal();
		t_abort();
		t_repeat();
		t_wait();
		chk(16'(i_rcd_host.nacks), 16'h0000);
		test_done();
	end
	initial begin
		#400000;
		failures++;
		test_done();
	end
endmodule
